// ==== pwa_top.sv ====
// Agent warning flags, alert history and banked temperature registers
`timescale 1ns/1ps
`include "pwa_map.svh"
module pwa_top
  import pwa_pkg::*;
#(
  parameter int AGENTS = 4
) (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RSTN_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire pwa_txn_s   TXN_I,
  output logic      [7:0] REG_RDATA_O,
  output logic      [1:0] SPEED_SEL_O,
  output logic            BIT_TICK_O,
  output logic            IRQ_O
);

  pwa_state_s        q;
  pwa_state_s        d;
  logic [AGENTS-1:0] trk_alert;
  logic [AGENTS-1:0] trk_absent;
  logic [AGENTS-1:0] trk_upd;
  logic [3:0]        alert_rise;
  logic [3:0]        absent_rise;
  logic              rd_hist;
  logic              rd_stat;
  logic              tick;

  // Warning register image: flags, bank and speed
  function automatic logic [7:0] warn_word(
    input logic [1:0] bank,
    input logic [1:0] spd,
    input logic [3:0] alert,
    input logic [3:0] absent
  );
    logic [3:0] flags;
    flags = bank[1] ? absent : alert;
    warn_word = {flags, bank, spd};
  endfunction

  // History register image, gated by bank bit 0
  function automatic logic [7:0] hist_word(
    input logic       show,
    input logic [3:0] hist
  );
    hist_word = show ? {hist, 4'h0} : 8'h00;
  endfunction

  // Route each transaction to its agent tracker
  always_comb begin
    trk_upd = '0;
    if (TXN_I.done) begin
      trk_upd[TXN_I.agent] = 1'b1;
    end
  end

  // One FCS and presence tracker per agent
  genvar g;
  generate
    for (g = 0; g < AGENTS; g++) begin : g_trk
      pwa_flag_track #(
        .DEPTH (`PWA_FCS_DEPTH)
      ) u_trk (
        .clk_i     (SYS_CLK_I),
        .rstn_i    (RSTN_I),
        .upd_i     (trk_upd[g]),
        .fcs_bad_i (TXN_I.fcs_bad),
        .absent_i  (TXN_I.absent),
        .alert_o   (trk_alert[g]),
        .absent_o  (trk_absent[g])
      );
    end
  endgenerate

  // Link bit-rate enable from the speed field
  pwa_rate_div u_div (
    .clk_i   (SYS_CLK_I),
    .rstn_i  (RSTN_I),
    .speed_i (q.speed),
    .tick_o  (tick)
  );

  // Rising edges of the tracker outputs
  assign alert_rise  = trk_alert & ~q.alert_prev;
  assign absent_rise = trk_absent & ~q.absent_prev;

  // Reads that clear sticky bits
  assign rd_hist = REG_RD_I && (REG_ADDR_I == `PWA_OFF_HIST) && q.bank[0];
  assign rd_stat = REG_RD_I && (REG_ADDR_I == `PWA_OFF_IRQ_STAT);

  // Next-state logic for registers and read data
  always_comb begin
    d             = q;
    d.alert_prev  = trk_alert;
    d.absent_prev = trk_absent;

    // Alert rise bits, set beats read clear
    if (rd_hist) begin
      d.hist = `PWA_HIST_RST;
    end
    d.hist = d.hist | alert_rise;

    // Interrupt status, set beats read clear
    if (rd_stat) begin
      d.irq_stat = `PWA_IRQ_RST;
    end
    d.irq_stat = d.irq_stat | {absent_rise, alert_rise};

    // Latest good temperature sample
    if (TXN_I.done && !TXN_I.absent && !TXN_I.fcs_bad) begin
      d.temp_hi = TXN_I.temp[15:8];
      d.temp_lo = TXN_I.temp[7:0];
    end

    // Software writes
    if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        `PWA_OFF_WARN: begin
          d.bank  = REG_WDATA_I[`PWA_WARN_BANK_LSB +: 2];
          d.speed = pwa_speed_e'(REG_WDATA_I[`PWA_WARN_SPD_LSB +: 2]);
        end
        `PWA_OFF_IRQ_MASK: begin
          d.irq_mask = REG_WDATA_I;
        end
        default: begin
        end
      endcase
    end

    // Read data, zero for unmapped offsets
    d.rdata = 8'h00;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `PWA_OFF_WARN: begin
          d.rdata = warn_word(q.bank, q.speed, trk_alert, trk_absent);
        end
        `PWA_OFF_HIST: begin
          d.rdata = hist_word(q.bank[0], q.hist);
        end
        `PWA_OFF_TEMP_HI: begin
          unique case (q.bank)
            2'b00:   d.rdata = q.temp_hi;
            2'b01:   d.rdata = {4'h0, trk_absent};
            default: d.rdata = 8'h00;
          endcase
        end
        `PWA_OFF_TEMP_LO: begin
          unique case (q.bank)
            2'b00:   d.rdata = q.temp_lo;
            default: d.rdata = 8'h00;
          endcase
        end
        `PWA_OFF_IRQ_STAT: begin
          d.rdata = q.irq_stat;
        end
        `PWA_OFF_IRQ_MASK: begin
          d.rdata = q.irq_mask;
        end
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end

    // Level interrupt while an unmasked status bit is set
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  // State register, everything zero at reset
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign REG_RDATA_O = q.rdata;
  assign SPEED_SEL_O = q.speed;
  assign BIT_TICK_O  = tick;
  assign IRQ_O       = q.irq;

endmodule

// ==== pwa_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef PWA_MAP_SVH
`define PWA_MAP_SVH

`define PWA_OFF_WARN      8'hE8
`define PWA_OFF_HIST      8'hEA
`define PWA_OFF_TEMP_HI   8'hEE
`define PWA_OFF_TEMP_LO   8'hEF
`define PWA_OFF_IRQ_STAT  8'hF8
`define PWA_OFF_IRQ_MASK  8'hF9

`define PWA_WARN_FLAG_LSB 4
`define PWA_WARN_BANK_LSB 2
`define PWA_WARN_SPD_LSB  0
`define PWA_HIST_LSB      4

`define PWA_WARN_RST      8'h00
`define PWA_HIST_RST      4'h0
`define PWA_IRQ_RST       8'h00

`define PWA_FCS_DEPTH     3
`define PWA_CLK_HZ        100000000
`define PWA_SPD0_HZ       1500000
`define PWA_SPD1_HZ       750000
`define PWA_SPD2_HZ       375000
`define PWA_SPD3_HZ       187000
`define PWA_DIV0          (`PWA_CLK_HZ / `PWA_SPD0_HZ)
`define PWA_DIV1          (`PWA_CLK_HZ / `PWA_SPD1_HZ)
`define PWA_DIV2          (`PWA_CLK_HZ / `PWA_SPD2_HZ)
`define PWA_DIV3          (`PWA_CLK_HZ / `PWA_SPD3_HZ)

`endif

// ==== pwa_pkg.sv ====
// Types shared by the agent warning status block
package pwa_pkg;

  typedef enum logic [1:0] {
    PWA_SPD_1M5  = 2'b00,
    PWA_SPD_750K = 2'b01,
    PWA_SPD_375K = 2'b10,
    PWA_SPD_187K = 2'b11
  } pwa_speed_e;

  // One finished link transaction
  typedef struct packed {
    logic        done;
    logic [1:0]  agent;
    logic        fcs_bad;
    logic        absent;
    logic [15:0] temp;
  } pwa_txn_s;

  // Whole state of the top module
  typedef struct packed {
    pwa_speed_e  speed;
    logic [1:0]  bank;
    logic [3:0]  hist;
    logic [3:0]  alert_prev;
    logic [3:0]  absent_prev;
    logic [7:0]  temp_hi;
    logic [7:0]  temp_lo;
    logic [7:0]  irq_stat;
    logic [7:0]  irq_mask;
    logic [7:0]  rdata;
    logic        irq;
  } pwa_state_s;

endpackage

// ==== pwa_flag_track.sv ====
// Per-agent FCS history and presence tracker
`timescale 1ns/1ps
`include "pwa_map.svh"
module pwa_flag_track #(
  parameter int DEPTH = `PWA_FCS_DEPTH
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic upd_i,
  input  wire logic fcs_bad_i,
  input  wire logic absent_i,
  output logic      alert_o,
  output logic      absent_o
);

  typedef struct packed {
    logic [DEPTH-1:0] fcs_hist;
    logic             absent;
  } pwa_trk_s;

  pwa_trk_s q;
  pwa_trk_s d;

  // Shift in one result per transaction of this agent
  always_comb begin
    d = q;
    if (upd_i) begin
      d.fcs_hist = {q.fcs_hist[DEPTH-2:0], fcs_bad_i};
      d.absent   = absent_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Alert while any of the last transactions failed
  assign alert_o  = |q.fcs_hist;
  assign absent_o = q.absent;

endmodule

// ==== pwa_rate_div.sv ====
// Link bit-rate enable divider
`timescale 1ns/1ps
`include "pwa_map.svh"
module pwa_rate_div
  import pwa_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire pwa_speed_e speed_i,
  output logic            tick_o
);

  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } pwa_div_s;

  pwa_div_s q;
  pwa_div_s d;

  // Cycles per link bit for a speed code
  function automatic logic [9:0] div_of(input pwa_speed_e s);
    unique case (s)
      PWA_SPD_1M5:  div_of = 10'(`PWA_DIV0);
      PWA_SPD_750K: div_of = 10'(`PWA_DIV1);
      PWA_SPD_375K: div_of = 10'(`PWA_DIV2);
      PWA_SPD_187K: div_of = 10'(`PWA_DIV3);
    endcase
  endfunction

  // Count up, pulse and wrap at the period end
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt >= div_of(speed_i) - 10'h001) begin
      d.cnt  = 10'h000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 10'h001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;

endmodule

// ==== pwa_top_assertions.sv ====
// Port checks for the warning status top
`timescale 1ns/1ps
module pwa_top_assertions
  import pwa_pkg::*;
#(
  parameter int AGENTS = 4
) (
  input wire logic       SYS_CLK_I,
  input wire logic       RSTN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire pwa_txn_s   TXN_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic [1:0] SPEED_SEL_O,
  input wire logic       BIT_TICK_O,
  input wire logic       IRQ_O
);
  default clocking dc @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Register bus steps
  sequence s_rd(a);
    REG_RD_I && REG_ADDR_I == a;
  endsequence
  sequence s_rd_hist;
    s_rd(8'hEA) ##0 !TXN_I.done;
  endsequence
  a_speed_set: assert property (
    REG_WR_I && REG_ADDR_I == 8'hE8 |=>
    SPEED_SEL_O == $past(REG_WDATA_I[1:0]))
    else $error("speed not taken");
  a_speed_hold: assert property (
    !REG_WR_I |=> $stable(SPEED_SEL_O))
    else $error("speed moved");
  a_speed_read: assert property (
    s_rd(8'hE8) |=> REG_RDATA_O[1:0] == $past(SPEED_SEL_O))
    else $error("speed readback");
  a_hist_low: assert property (
    s_rd(8'hEA) |=> REG_RDATA_O[3:0] == 4'h0)
    else $error("history low bits");
  a_hole_zero: assert property (
    s_rd(8'hE9) |=> REG_RDATA_O == 8'h00)
    else $error("reserved read");
  a_rd_idle: assert property (
    !REG_RD_I |=> REG_RDATA_O == 8'h00)
    else $error("stray read data");
  a_tick_gap: assert property (
    BIT_TICK_O |=> !BIT_TICK_O [*8])
    else $error("tick too close");
  a_hist_clear: assert property (
    !TXN_I.done ##1 s_rd_hist ##1 s_rd_hist |=> REG_RDATA_O == 8'h00)
    else $error("history not cleared");
endmodule
bind pwa_top pwa_top_assertions #(.AGENTS(AGENTS)) u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .TXN_I(TXN_I), .REG_RDATA_O(REG_RDATA_O), .SPEED_SEL_O(SPEED_SEL_O),
  .BIT_TICK_O(BIT_TICK_O), .IRQ_O(IRQ_O));

// ==== pwa_agent_model.sv ====
// Behavioural thermal agent handing finished transactions to the block
`timescale 1ns/1ps
module pwa_agent_model
  import pwa_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       go_i,
  input  wire pwa_txn_s   req_i,
  input  wire logic [3:0] wait_i,
  output pwa_txn_s        txn_o
);
  pwa_txn_s   hold_q;
  logic [4:0] cnt_q;
  // Stall wait_i cycles, one done pulse; fields scramble otherwise
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_q <= '0;
      cnt_q  <= '0;
      txn_o  <= '0;
    end else begin
      if (go_i) begin
        hold_q <= req_i;
        cnt_q  <= {1'b1, wait_i};
        txn_o  <= {1'b0, ~txn_o[19:0]};
      end else if (cnt_q == 5'h10) begin
        txn_o <= {1'b1, hold_q[19:0]};
        cnt_q <= '0;
      end else begin
        txn_o <= {1'b0, ~txn_o[19:0]};
        if (cnt_q[4]) begin
          cnt_q <= cnt_q - 5'h01;
        end
      end
    end
  end
endmodule

// ==== pwa_top_test.sv ====
// Self-checking bench for the warning status block
`timescale 1ns/1ps
module pwa_top_test;
  import pwa_pkg::*;
  logic        clk, rstn, wr, rd, go, tick, irq;
  logic [7:0]  addr, wdata, rdata;
  logic [1:0]  spd;
  logic [3:0]  dly;
  logic [25:0] rows [4];
  pwa_txn_s    req, txn;
  int          n_mismatch, n_compared;

  pwa_top #(.AGENTS(4)) uut (.SYS_CLK_I(clk), .RSTN_I(rstn),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .TXN_I(txn), .REG_RDATA_O(rdata), .SPEED_SEL_O(spd),
    .BIT_TICK_O(tick), .IRQ_O(irq));
  pwa_agent_model u_agent (.clk_i(clk), .rstn_i(rstn), .go_i(go),
    .req_i(req), .wait_i(dly), .txn_o(txn));

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input logic [7:0] a, exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), 16'(rdata), 16'(exp));
    @(posedge clk);
  endtask

  task automatic wreg(input logic [7:0] a, d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Interrupt level, looked at once settled, ends on an edge
  task automatic ichk(input logic exp);
    #1 chk("irq", 16'(irq), 16'(exp));
    @(posedge clk);
  endtask

  task automatic agent(input logic [1:0] ag, input logic bad, ab,
                       input logic [3:0] w);
    req <= '{1'b0, ag, bad, ab, 16'hA55A ^ {14'h0, ag}};
    dly <= w;
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (int'(w) + 4) @(posedge clk);
  endtask

  task automatic period(input logic [9:0] exp);
    int n;
    n = 0;
    // Look one step after each edge, where the tick has settled
    do begin
      @(posedge clk);
      #1;
    end while (!tick);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!tick && n < 600);
    chk("tick", 16'(n), 16'(exp));
    @(posedge clk);
  endtask

  initial begin
    rows = '{{8'hF0, 8'h00, 10'd66}, {8'h05, 8'h05, 10'd133},
             {8'h0A, 8'h0A, 10'd266}, {8'h03, 8'h03, 10'd534}};
    {rstn, wr, rd, go, addr, wdata, dly} = '0;
    req = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(8'hE8, 8'h00);
    rchk(8'hEA, 8'h00);
    rchk(8'hE9, 8'h00);
    // Speed codes, read-only flags and bit periods
    foreach (rows[i]) begin
      wreg(8'hE8, rows[i][25:18]);
      rchk(8'hE8, rows[i][17:10]);
      period(rows[i][9:0]);
    end
    // Temperature bytes, bad FCS keeps last good sample
    wreg(8'hE8, 8'h00);
    agent(2'd0, 1'b0, 1'b0, 4'd0);
    rchk(8'hEE, 8'hA5);
    rchk(8'hEF, 8'h5A);
    agent(2'd0, 1'b1, 1'b0, 4'd9);
    rchk(8'hEE, 8'hA5);
    rchk(8'hE8, 8'h10);
    // Interrupt masked, unmasked, cleared by status read
    ichk(1'b0);
    wreg(8'hF9, 8'h01);
    ichk(1'b1);
    rchk(8'hF8, 8'h01);
    ichk(1'b0);
    // History shown, set on alert, cleared by back-to-back read
    wreg(8'hE8, 8'h04);
    rchk(8'hEA, 8'h10);
    agent(2'd1, 1'b1, 1'b0, 4'd3);
    addr <= 8'hEA;
    rd   <= 1'b1;
    @(posedge clk);
    #1 chk("hist", 16'(rdata), 16'h0020);
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("hist", 16'(rdata), 16'h0000);
    @(posedge clk);
    // Alert holds for two good transactions, clears on the third
    for (int k = 0; k < 3; k++) begin
      agent(2'd1, 1'b0, 1'b0, 4'd0);
      rchk(8'hE8, (k < 2) ? 8'h34 : 8'h14);
    end
    // Alert rising in the clearing read cycle survives it
    fork
      agent(2'd2, 1'b1, 1'b0, 4'd0);
      begin
        repeat (3) @(posedge clk);
        rchk(8'hEA, 8'h00);
      end
    join
    rchk(8'hEA, 8'h40);
    // Absent agent shown in bank 01 and through bit 3
    agent(2'd3, 1'b0, 1'b1, 4'd2);
    rchk(8'hEE, 8'h08);
    wreg(8'hE8, 8'h08);
    rchk(8'hE8, 8'h88);
    rchk(8'hEE, 8'h00);
    // Reset in mid-run clears every field
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(8'hE8, 8'h00);
    rchk(8'hEE, 8'h00);
    rchk(8'hF8, 8'h00);
    results();
  end
endmodule
